// >>> core_power_mode_control.sv
// core power mode control: mode handshake, active hint, domain control, q-channels
// Notes on behaviour
// - domains are on, retention or off
// - debug domain only on or off
// - cache rams retained only in cache retention modes
// - on but clock stopped counts as low power
// - deny requests between unconnected modes
// - hint presents each intermediate cache step
// - memory retention without cache never hinted
// - off to memory retention ok, never back
// - no auto invalidate from or via memory retention
// - request for the current mode always accepted
// - no-cache modes clear active bits, select all off
// - cache power-up from on flips only bit 16
// - secondary machine routes cache changes through on
// - drive clocks, resets and minimum mode hint
// - separate q-channels for debug power and clocks
// - full retention keeps all logic state
// - cache memory retention powers logic off
// - wakeup unit domain may stay powered
// - requested-state encoding with cache bit four
// - hint bits 8, 5, 2 and 16 only
// - undefined requested state is denied
// - cold reset off, initial state sampled early
`timescale 1ns/1ps
module core_power_mode_control
	import pwr_pkg::*;
(
	input wire logic clk_sys, // core clock, 40 MHz
	input wire logic rst, // synchronous reset, active high
	input wire logic core_mode_request, // p-channel request
	input wire logic [PST_W-1:0] core_requested_state, // p-channel requested state
	output logic core_mode_accept, // p-channel accept
	output logic core_mode_deny, // p-channel deny
	output logic [HINT_W-1:0] core_mode_active_hint, // minimum required mode
	input wire logic [1:0] need_core_state, // core domain state wanted by low-power logic
	input wire logic sw_icache_active, // software instruction cache active bit
	input wire logic sw_dcache_active, // software data cache active bit
	input wire logic [1:0] sw_ram_lp_select, // software ram low-power select
	input wire logic auto_invalidate_disable, // suppress automatic cache invalidation
	input wire logic cfg_we, // graph table write strobe
	input wire logic [2:0] cfg_addr, // graph table source row
	input wire logic [MODE_N-1:0] cfg_row, // graph table target mask
	input wire logic clk_idle, // core may have its clock gated
	input wire logic debug_busy, // debug logic needs power and clock
	input wire logic wakeup_armed, // wakeup unit must watch for events
	input wire logic core_clk_qreq_n, // core clock q-channel request
	output logic core_clk_qaccept_n, // core clock q-channel accept
	output logic core_clk_qdeny, // core clock q-channel deny
	output logic core_clk_qactive, // core clock q-channel active
	input wire logic debug_pwr_qreq_n, // debug power q-channel request
	output logic debug_pwr_qaccept_n, // debug power q-channel accept
	output logic debug_pwr_qdeny, // debug power q-channel deny
	output logic debug_pwr_qactive, // debug power q-channel active
	input wire logic debug_clk_qreq_n, // debug clock q-channel request
	output logic debug_clk_qaccept_n, // debug clock q-channel accept
	output logic debug_clk_qdeny, // debug clock q-channel deny
	output logic debug_clk_qactive, // debug clock q-channel active
	output logic [1:0] core_logic_domain, // core logic domain state
	output logic [1:0] cache_ram_domain, // cache ram domain state
	output logic debug_domain, // debug domain powered
	output logic wakeup_domain_on, // wakeup unit domain powered
	output logic core_reset_hold, // core logic held in reset
	output logic cache_reset_hold, // cache rams held in reset
	output logic core_clock_run, // core clock enabled
	output logic core_low_power, // core in a low-power state
	output logic icache_active_bit, // effective instruction cache active
	output logic dcache_active_bit, // effective data cache active
	output logic [1:0] ram_low_power_select, // effective ram low-power select
	output logic auto_invalidate_start, // one-cycle cache invalidation start
	output logic [2:0] current_mode // present power and operating mode
);
	// p-channel handshake states, gray along init-idle-look-decide-hold
	typedef enum logic [2:0]
	{
		PC_INIT = 3'h0,
		PC_IDLE = 3'h1,
		PC_LOOK = 3'h3,
		PC_DECIDE = 3'h2,
		PC_HOLD = 3'h6
	} pc_t;
	// secondary hint sequencer states
	typedef enum logic [1:0]
	{
		SEQ_DIRECT = 2'h0,
		SEQ_TO_ON = 2'h1,
		SEQ_FLIP = 2'h3
	} seq_t;

	pc_t pc; // handshake state
	seq_t seq; // hint sequencer state
	mode_t cur; // applied mode
	logic [2:0] init_cnt; // cycles since reset release
	logic req_s; // settled request
	logic [PST_W-1:0] pst_s; // settled requested state
	logic [QC_N-1:0] qreq_n_s; // settled q-channel requests
	logic [QC_N-1:0] qacc_n; // q-channel accepts
	logic [QC_N-1:0] qdeny; // q-channel denies
	logic [QC_N-1:0] qallow; // quiescence may be granted
	logic [MODE_N-1:0] graph_row; // permitted targets from cur
	logic [3:0] tgt_dec; // decoded request
	logic tgt_ok; // request encoding valid
	mode_t tgt; // requested mode
	logic link_ok; // move is on the graph
	logic cache_need; // software wants the caches
	mode_t want; // minimum mode from core state
	logic flip; // cache domain must change
	mode_t pick; // mode shown on the hint

	// p-channel inputs cross in from the controller's clock
	pin_sync #(.W(PST_W + 1), .RST_VAL('0)) u_psync
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.d({core_mode_request, core_requested_state}),
		.q({req_s, pst_s})
	);

	// q-channel requests idle high, so they reset high
	pin_sync #(.W(QC_N), .RST_VAL('1)) u_qsync
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.d({debug_clk_qreq_n, debug_pwr_qreq_n, core_clk_qreq_n}),
		.q(qreq_n_s)
	);

	mode_graph_table u_graph
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.cfg_we(cfg_we),
		.cfg_addr(cfg_addr),
		.cfg_row(cfg_row),
		.rd_addr(cur),
		.rd_row(graph_row)
	);

	// request decode and graph check
	always_comb
	begin
		tgt_dec = decode_pstate(pst_s);
		tgt_ok = tgt_dec[3];
		tgt = mode_t'(tgt_dec[2:0]);
		// memory retention may never drop straight to off
		link_ok = (tgt == cur) ||
			(graph_row[tgt] && !((cur == M_MEMRET_C || cur == M_MEMRET_NC) && tgt == M_OFF));
	end

	// p-channel handshake, mode applied on accept
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pc <= PC_INIT;
			init_cnt <= '0;
			cur <= M_OFF;
			core_mode_accept <= 1'b0;
			core_mode_deny <= 1'b0;
		end
		else
		begin
			case (pc)
				PC_INIT:
				begin
					init_cnt <= init_cnt + 3'h1;
					// take off, memory retention or on as initial mode
					if (init_cnt == INIT_CYCLES)
					begin
						if (tgt_ok && (tgt == M_OFF || tgt == M_MEMRET_C || tgt == M_MEMRET_NC ||
							is_on(tgt)))
						begin
							cur <= tgt;
						end
						pc <= PC_IDLE;
					end
				end
				PC_IDLE:
				begin
					// graph row for cur is refreshed during look
					if (req_s)
					begin
						pc <= PC_LOOK;
					end
				end
				PC_LOOK:
				begin
					pc <= PC_DECIDE;
				end
				PC_DECIDE:
				begin
					if (tgt_ok && link_ok)
					begin
						core_mode_accept <= 1'b1;
						cur <= tgt;
					end
					else
					begin
						core_mode_deny <= 1'b1;
					end
					pc <= PC_HOLD;
				end
				PC_HOLD:
				begin
					// answer stands until the request is withdrawn
					if (!req_s)
					begin
						core_mode_accept <= 1'b0;
						core_mode_deny <= 1'b0;
						pc <= PC_IDLE;
					end
				end
				default: pc <= PC_IDLE;
			endcase
		end
	end

	// invalidate only on a cold cache power-up, never via memory retention
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			auto_invalidate_start <= 1'b0;
		end
		else
		begin
			auto_invalidate_start <= (pc == PC_DECIDE) && tgt_ok && link_ok &&
				(tgt == M_ON_C) && !auto_invalidate_disable &&
				(cur == M_OFF || cur == M_ON_NC || cur == M_WARM);
		end
	end

	// minimum mode from core needs and cache requests
	always_comb
	begin
		cache_need = sw_icache_active || sw_dcache_active;
		case (need_core_state)
			DOM_ON: want = cache_need ? M_ON_C : M_ON_NC;
			DOM_RET: want = cache_need ? M_FULLRET_C : M_FULLRET_NC;
			// off replaces memory retention without cache
			default: want = cache_need ? M_MEMRET_C : M_OFF;
		endcase
		flip = (has_cache(want) != has_cache(cur)) && want != M_OFF && cur != M_OFF &&
			cur != M_WARM;
		// cache changes are shown through a full-on mode
		case (seq)
			SEQ_TO_ON: pick = has_cache(cur) ? M_ON_C : M_ON_NC;
			// flip only the cache bit while on
			SEQ_FLIP: pick = has_cache(want) ? M_ON_C : M_ON_NC;
			// stepping starts in the first cycle, so the bare target never leaks out
			default: pick = !flip ? want : is_on(cur) ? (has_cache(want) ? M_ON_C : M_ON_NC) :
				(has_cache(cur) ? M_ON_C : M_ON_NC);
		endcase
	end

	// secondary sequencer steps the hint through each stage
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			seq <= SEQ_DIRECT;
		end
		else
		begin
			case (seq)
				SEQ_DIRECT:
				begin
					if (flip)
					begin
						seq <= is_on(cur) ? SEQ_FLIP : SEQ_TO_ON;
					end
				end
				SEQ_TO_ON:
				begin
					if (!flip)
					begin
						seq <= SEQ_DIRECT;
					end
					else if (is_on(cur))
					begin
						seq <= SEQ_FLIP;
					end
				end
				SEQ_FLIP:
				begin
					if (!flip)
					begin
						seq <= SEQ_DIRECT;
					end
				end
				default: seq <= SEQ_DIRECT;
			endcase
		end
	end

	// hint register, held at off until the initial mode is taken
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			core_mode_active_hint <= '0;
		end
		else
		begin
			// one-hot mode bit plus cache bit
			core_mode_active_hint <= (pc == PC_INIT) ? '0 : mode_hint(pick);
		end
	end

	// permission to quiesce each q-channel
	always_comb
	begin
		qallow[QC_CORE_CLK] = clk_idle;
		qallow[QC_DBG_PWR] = !debug_busy;
		qallow[QC_DBG_CLK] = !debug_busy;
	end

	// q-channel responders for core clock, debug power and debug clock
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			qacc_n <= '1;
			qdeny <= '0;
		end
		else
		begin
			for (int i = 0; i < QC_N; i++)
			begin
				if (qreq_n_s[i])
				begin
					// release ends both accept and deny
					qacc_n[i] <= 1'b1;
					qdeny[i] <= 1'b0;
				end
				else if (qacc_n[i] && !qdeny[i])
				begin
					if (qallow[i])
					begin
						qacc_n[i] <= 1'b0;
					end
					else
					begin
						qdeny[i] <= 1'b1;
					end
				end
			end
		end
	end

	// q-channel outputs
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			core_clk_qaccept_n <= 1'b1;
			core_clk_qdeny <= 1'b0;
			core_clk_qactive <= 1'b0;
			debug_pwr_qaccept_n <= 1'b1;
			debug_pwr_qdeny <= 1'b0;
			debug_pwr_qactive <= 1'b0;
			debug_clk_qaccept_n <= 1'b1;
			debug_clk_qdeny <= 1'b0;
			debug_clk_qactive <= 1'b0;
		end
		else
		begin
			core_clk_qaccept_n <= qacc_n[QC_CORE_CLK];
			core_clk_qdeny <= qdeny[QC_CORE_CLK];
			core_clk_qactive <= !clk_idle;
			debug_pwr_qaccept_n <= qacc_n[QC_DBG_PWR];
			debug_pwr_qdeny <= qdeny[QC_DBG_PWR];
			debug_pwr_qactive <= debug_busy;
			debug_clk_qaccept_n <= qacc_n[QC_DBG_CLK];
			debug_clk_qdeny <= qdeny[QC_DBG_CLK];
			debug_clk_qactive <= debug_busy;
		end
	end

	// domain states, resets and clocks follow the applied mode
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			core_logic_domain <= DOM_OFF;
			cache_ram_domain <= DOM_OFF;
			core_reset_hold <= 1'b1;
			cache_reset_hold <= 1'b1;
			core_clock_run <= 1'b0;
			core_low_power <= 1'b1;
			debug_domain <= 1'b1;
			wakeup_domain_on <= 1'b1;
			current_mode <= M_OFF;
		end
		else
		begin
			// core on, retained or off; warm reset holds it off
			// cache memory retention powers logic down
			core_logic_domain <= is_on(cur) ? DOM_ON :
				(cur == M_FULLRET_C || cur == M_FULLRET_NC) ? DOM_RET : DOM_OFF;
			// cache retention only in the two cache retention modes
			cache_ram_domain <= (cur == M_ON_C) ? DOM_ON :
				(cur == M_FULLRET_C || cur == M_MEMRET_C) ? DOM_RET : DOM_OFF;
			core_reset_hold <= !is_on(cur) && cur != M_FULLRET_C && cur != M_FULLRET_NC;
			cache_reset_hold <= !has_cache(cur);
			core_clock_run <= is_on(cur) && qacc_n[QC_CORE_CLK];
			// powered but clock stopped is low power
			core_low_power <= !is_on(cur) || !qacc_n[QC_CORE_CLK];
			// debug domain is on or off only, set by its own channel
			debug_domain <= qacc_n[QC_DBG_PWR];
			// wakeup domain survives core power-down while armed
			wakeup_domain_on <= wakeup_armed || is_on(cur);
			current_mode <= cur;
		end
	end

	// no-cache modes show caches inactive and rams selected off
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			icache_active_bit <= 1'b0;
			dcache_active_bit <= 1'b0;
			ram_low_power_select <= RLP_ALL_OFF;
		end
		else
		begin
			icache_active_bit <= has_cache(cur) && sw_icache_active;
			dcache_active_bit <= has_cache(cur) && sw_dcache_active;
			ram_low_power_select <= has_cache(cur) ? sw_ram_lp_select : RLP_ALL_OFF;
		end
	end

	property p_bad_deny;
		@(posedge clk_sys) disable iff (rst)
		(pc == PC_DECIDE && !tgt_ok) |=> core_mode_deny && !core_mode_accept;
	endproperty
	a_bad_deny: assert property (p_bad_deny) else $error("bad state not denied");

	property p_self_accept;
		@(posedge clk_sys) disable iff (rst)
		(pc == PC_DECIDE && tgt_ok && tgt == cur) |=> core_mode_accept && cur == $past(cur);
	endproperty
	a_self_accept: assert property (p_self_accept) else $error("self move refused");

	property p_unlinked_deny;
		@(posedge clk_sys) disable iff (rst)
		(pc == PC_DECIDE && tgt_ok && tgt != cur && !graph_row[tgt]) |=> core_mode_deny;
	endproperty
	a_unlinked_deny: assert property (p_unlinked_deny) else $error("unlinked move taken");

	property p_mem_off;
		@(posedge clk_sys) disable iff (rst)
		(pc == PC_DECIDE && cur == M_MEMRET_C && tgt == M_OFF) |=> core_mode_deny ##0 cur == M_MEMRET_C;
	endproperty
	a_mem_off: assert property (p_mem_off) else $error("memory retention dropped to off");

	property p_no_memret_nc;
		@(posedge clk_sys) disable iff (rst)
		core_mode_active_hint[HINT_MEM_BIT] |-> core_mode_active_hint[HINT_CACHE_BIT];
	endproperty
	a_no_memret_nc: assert property (p_no_memret_nc) else $error("memret no-cache hinted");

	property p_hint_unused;
		@(posedge clk_sys) disable iff (rst)
		(core_mode_active_hint & ~mode_hint(M_ON_C) & ~mode_hint(M_FULLRET_C) &
			~mode_hint(M_MEMRET_C)) == '0;
	endproperty
	a_hint_unused: assert property (p_hint_unused) else $error("unused hint bit set");

	property p_no_inval;
		@(posedge clk_sys) disable iff (rst)
		(pc == PC_DECIDE && (cur == M_MEMRET_C || cur == M_MEMRET_NC)) |=> !auto_invalidate_start [*2];
	endproperty
	a_no_inval: assert property (p_no_inval) else $error("invalidate after retention");

	property p_nocache_bits;
		@(posedge clk_sys) disable iff (rst)
		!has_cache(cur) |=> ram_low_power_select == RLP_ALL_OFF && !icache_active_bit &&
			!dcache_active_bit;
	endproperty
	a_nocache_bits: assert property (p_nocache_bits) else $error("no-cache bits wrong");

	property p_route_on;
		@(posedge clk_sys) disable iff (rst)
		(seq == SEQ_TO_ON && pc != PC_INIT) |=> core_mode_active_hint[HINT_ON_BIT];
	endproperty
	a_route_on: assert property (p_route_on) else $error("cache change not via on");

	property p_answer_holds;
		@(posedge clk_sys) disable iff (rst)
		(core_mode_accept && req_s) |=> core_mode_accept;
	endproperty
	a_answer_holds: assert property (p_answer_holds) else $error("accept dropped early");
endmodule

// >>> core_power_mode_control_test.sv
// self-checking bench for the core power mode control
`timescale 1ns/1ps
module core_power_mode_control_test;
	import pwr_pkg::*;
	logic clk_sys; // core clock
	logic rst = 1'b1; // synchronous reset
	logic req; // mode request
	logic [PST_W-1:0] pst; // requested state
	logic acc, den, dbg, wake, lowp, icache, dc, inv; // single-bit outputs
	logic [5:0] st; // qactive x3, reset holds, clock run
	logic [1:0] need = 2'h2; // wanted core state
	logic [HINT_W-1:0] hint; // active hint
	logic [1:0] core_dom, ram_dom, rlp; // domain states, ram select
	logic [2:0] mode; // present mode
	logic [2:0] cfg_addr = 3'h0; // table row
	logic [7:0] cfg_row = 8'h00; // table contents
	logic cfg_we = 1'b0, sw_i = 1'b0, inv_dis = 1'b0; // control inputs
	logic idle = 1'b1, busy = 1'b0, armed = 1'b0; // quiescence inputs
	logic [QC_N-1:0] qrn; // q-channel requests
	wire [QC_N-1:0] qan, qdn; // q-channel answers
	logic [7:0] n_inv = 8'h00, n_dbg = 8'h00; // pulse and quiesce counts
	int num_errors = 0; // mismatches
	int n_tests = 0; // comparisons

	pwr_ctrl_model i_pctl (.clk_sys(clk_sys), .req(req), .pstate(pst), .acc(acc), .den(den),
		.qreq_n(qrn), .qacc_n(qan), .qden(qdn));

	core_power_mode_control i_dut (.clk_sys(clk_sys), .rst(rst), .core_mode_request(req),
		.core_requested_state(pst), .core_mode_accept(acc), .core_mode_deny(den),
		.core_mode_active_hint(hint), .need_core_state(need), .sw_icache_active(sw_i),
		.sw_dcache_active(sw_i), .sw_ram_lp_select(2'h0), .auto_invalidate_disable(inv_dis),
		.cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_row(cfg_row), .clk_idle(idle),
		.debug_busy(busy), .wakeup_armed(armed), .core_clk_qreq_n(qrn[0]),
		.core_clk_qaccept_n(qan[0]), .core_clk_qdeny(qdn[0]), .core_clk_qactive(st[5]),
		.debug_pwr_qreq_n(qrn[1]), .debug_pwr_qaccept_n(qan[1]), .debug_pwr_qdeny(qdn[1]),
		.debug_pwr_qactive(st[4]), .debug_clk_qreq_n(qrn[2]), .debug_clk_qaccept_n(qan[2]),
		.debug_clk_qdeny(qdn[2]), .debug_clk_qactive(st[3]), .core_logic_domain(core_dom),
		.cache_ram_domain(ram_dom), .debug_domain(dbg), .wakeup_domain_on(wake),
		.core_reset_hold(st[2]), .cache_reset_hold(st[1]), .core_clock_run(st[0]),
		.core_low_power(lowp), .icache_active_bit(icache), .dcache_active_bit(dc),
		.ram_low_power_select(rlp),
		.auto_invalidate_start(inv), .current_mode(mode));

	// 40 MHz clock
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// count invalidate pulses and cycles with debug power quiesced
	always @(posedge clk_sys)
	begin
		if (inv === 1'b1)
			n_inv <= n_inv + 8'h01;
		if (dbg === 1'b0)
			n_dbg <= n_dbg + 8'h01;
	end

	// value comparison; case equality so unknowns never match
	task automatic chk(input logic [HINT_W-1:0] got, input logic [HINT_W-1:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// one mode handshake, answer compared as {accept, deny}
	task automatic hs(input logic [PST_W-1:0] st, input logic [1:0] exp);
		logic a, d;
		i_pctl.preq(st, a, d);
		chk({a, d}, exp);
	endtask

	// one q-channel handshake, answer compared as {accept, deny}
	task automatic qs(input int i, input logic [1:0] exp);
		logic a, d;
		i_pctl.qreq(i, a, d);
		chk({a, d}, exp);
	endtask

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// hang guard: the whole sequence needs well under 2000 cycles
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		num_errors++;
		close_out;
	end

	// main sequence; inputs change at the falling edge
	initial
	begin
		repeat (16) @(negedge clk_sys);
		chk({acc, den}, 2'h0);
		chk(mode, M_OFF);
		chk(hint, '0);
		chk(st, 6'h06);
		rst = 1'b0;
		repeat (8) @(negedge clk_sys);
		chk(mode, M_ON_NC);
		chk(core_dom, DOM_ON);
		chk(ram_dom, DOM_OFF);
		chk(st, 6'h03);
		$display("test reset done");
		hs({1'b0, PST_ON}, 2'h2);
		hs(5'h07, 2'h1);
		chk(mode, M_ON_NC);
		chk(hint, 21'h0_0100);
		// software wants caches while still without them
		sw_i = 1'b1;
		repeat (4) @(negedge clk_sys);
		chk(hint, 21'h1_0100);
		chk(icache, 1'b0);
		chk(rlp, RLP_ALL_OFF);
		hs({1'b1, PST_ON}, 2'h2);
		chk(mode, M_ON_C);
		chk(icache, 1'b1);
		chk(dc, 1'b1);
		chk(rlp, 2'h0);
		chk(st, 6'h01);
		chk(n_inv, 8'h01);
		$display("test cache on done");
		hs({1'b0, PST_FULL}, 2'h1);
		// open the on-with-cache row to full retention without cache
		cfg_addr = 3'h6;
		cfg_row = 8'hBD;
		cfg_we = 1'b1;
		@(negedge clk_sys);
		cfg_we = 1'b0;
		hs({1'b0, PST_FULL}, 2'h2);
		chk(core_dom, DOM_RET);
		chk(lowp, 1'b1);
		chk(st, 6'h02);
		chk(hint, 21'h0_0100);
		hs({1'b0, PST_ON}, 2'h2);
		chk(hint, 21'h1_0100);
		$display("test graph done");
		inv_dis = 1'b1;
		hs({1'b1, PST_ON}, 2'h2);
		hs({1'b1, PST_MEM}, 2'h2);
		chk(ram_dom, DOM_RET);
		chk(core_dom, DOM_OFF);
		chk(st, 6'h04);
		chk(wake, 1'b0);
		armed = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk(wake, 1'b1);
		hs({1'b0, PST_OFF}, 2'h1);
		inv_dis = 1'b0;
		hs({1'b1, PST_ON}, 2'h2);
		chk(n_inv, 8'h01);
		$display("test retention done");
		qs(QC_CORE_CLK, 2'h2);
		idle = 1'b0;
		qs(QC_CORE_CLK, 2'h1);
		qs(QC_DBG_PWR, 2'h2);
		chk(n_dbg != 8'h00, 1'b1);
		busy = 1'b1;
		qs(QC_DBG_CLK, 2'h1);
		chk(st, 6'h39);
		chk(lowp, 1'b0);
		$display("test q-channel done");
		need = 2'h1;
		repeat (3) @(negedge clk_sys);
		chk(hint, 21'h1_0020);
		need = 2'h0;
		repeat (3) @(negedge clk_sys);
		chk(hint, 21'h1_0004);
		sw_i = 1'b0;
		repeat (3) @(negedge clk_sys);
		chk(hint, 21'h0_0000);
		$display("test hint done");
		close_out;
	end
endmodule

// >>> mode_graph_table.sv
// permitted transition table, one row of target bits per source mode
`timescale 1ns/1ps
module mode_graph_table
	import pwr_pkg::*;
(
	input wire logic clk_sys, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic cfg_we, // write strobe for one row
	input wire logic [2:0] cfg_addr, // source mode of the row written
	input wire logic [MODE_N-1:0] cfg_row, // new target mask
	input wire logic [2:0] rd_addr, // source mode to look up
	output logic [MODE_N-1:0] rd_row // registered target mask
);
	logic [MODE_N-1:0] rows [MODE_N]; // the graph itself

	// rows reload the built-in graph at reset, then take configuration writes
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			for (int i = 0; i < MODE_N; i++)
			begin
				rows[i] <= GRAPH_DEFAULT[i*MODE_N +: MODE_N];
			end
		end
		else if (cfg_we)
		begin
			rows[cfg_addr] <= cfg_row;
		end
	end

	// read port is registered so the lookup costs one cycle
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			rd_row <= '0;
		end
		else
		begin
			rd_row <= rows[rd_addr];
		end
	end
endmodule

// >>> pin_sync.sv
// three-stage synchroniser that releases a value once the last two stages agree
`timescale 1ns/1ps
module pin_sync
	import pwr_pkg::*;
#(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	input wire logic clk_sys, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [W-1:0] d, // asynchronous inputs
	output logic [W-1:0] q // settled copy
);
	logic [W-1:0] s1; // first stage, read only by s2
	logic [W-1:0] s2; // second stage
	logic [W-1:0] s3; // third stage

	// shift chain runs through reset, so a pin held steady is settled at release
	always_ff @(posedge clk_sys)
	begin
		s1 <= d;
		s2 <= s1;
		s3 <= s2;
	end

	// a bus is taken only when stages two and three match
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			q <= RST_VAL;
		end
		else if (s2 == s3)
		begin
			q <= s3;
		end
	end
endmodule

// >>> pwr_ctrl_model.sv
// partner model: external power controller and clock controller handshakes
`timescale 1ns/1ps
module pwr_ctrl_model
	import pwr_pkg::*;
(
	input wire logic clk_sys, // core clock
	output logic req, // mode request
	output logic [PST_W-1:0] pstate, // requested state
	input wire logic acc, // mode accept
	input wire logic den, // mode deny
	output logic [QC_N-1:0] qreq_n, // q-channel requests
	input wire logic [QC_N-1:0] qacc_n, // q-channel accepts
	input wire logic [QC_N-1:0] qden // q-channel denies
);
	// initial state on without cache, held through reset
	initial
	begin
		req = 1'b0;
		pstate = {1'b0, PST_ON};
		qreq_n = '1;
	end

	// four-phase mode request; callers also try unlinked and undefined states and memory retention
	task automatic preq(input logic [PST_W-1:0] st, output logic a, output logic d);
		int n;
		@(negedge clk_sys);
		pstate = st;
		req = 1'b1;
		// state and request stay put until an answer shows
		for (n = 0; n < 60 && !(acc || den); n++)
			@(negedge clk_sys);
		a = acc;
		d = den;
		req = 1'b0;
		// state is not held once released, so show its inverse
		pstate = ~st;
		for (n = 0; n < 60 && (acc || den); n++)
			@(negedge clk_sys);
	endtask

	// q-channel quiescence request, same four phases
	task automatic qreq(input int i, output logic a, output logic d);
		int n;
		@(negedge clk_sys);
		qreq_n[i] = 1'b0;
		for (n = 0; n < 60 && qacc_n[i] && !qden[i]; n++)
			@(negedge clk_sys);
		a = ~qacc_n[i];
		d = qden[i];
		qreq_n[i] = 1'b1;
		for (n = 0; n < 60 && (!qacc_n[i] || qden[i]); n++)
			@(negedge clk_sys);
	endtask
endmodule

// >>> pwr_pkg.sv
// shared constants, types and decode functions for the core power mode control
package pwr_pkg;
	// widths of the mode request and hint buses
	localparam int HINT_W = 21;
	localparam int PST_W = 5;
	localparam int MODE_N = 8;
	// requested-state low-nibble codes
	localparam logic [3:0] PST_WARM = 4'h9;
	localparam logic [3:0] PST_ON = 4'h8;
	localparam logic [3:0] PST_FULL = 4'h5;
	localparam logic [3:0] PST_MEM = 4'h2;
	localparam logic [3:0] PST_OFF = 4'h0;
	localparam int PST_CACHE_BIT = 4;
	// hint bit positions
	localparam int HINT_ON_BIT = 8;
	localparam int HINT_FULL_BIT = 5;
	localparam int HINT_MEM_BIT = 2;
	localparam int HINT_CACHE_BIT = 16;
	// cycles after reset release before the initial state is taken
	localparam logic [2:0] INIT_CYCLES = 3'h3;
	// ram low-power select value meaning all cache rams powered off
	localparam logic [1:0] RLP_ALL_OFF = 2'h3;
	// q-channel slots
	localparam int QC_CORE_CLK = 0;
	localparam int QC_DBG_PWR = 1;
	localparam int QC_DBG_CLK = 2;
	localparam int QC_N = 3;
	// power and operating modes
	typedef enum logic [2:0]
	{
		M_OFF = 3'h0,
		M_MEMRET_NC = 3'h1,
		M_MEMRET_C = 3'h2,
		M_FULLRET_NC = 3'h3,
		M_FULLRET_C = 3'h4,
		M_ON_NC = 3'h5,
		M_ON_C = 3'h6,
		M_WARM = 3'h7
	} mode_t;
	// state of one power domain
	typedef enum logic [1:0]
	{
		DOM_OFF = 2'h0,
		DOM_RET = 2'h1,
		DOM_ON = 2'h2
	} dom_t;
	// permitted-target mask per source mode, row 7 in the top byte
	localparam logic [63:0] GRAPH_DEFAULT = 64'h60B5_CB40_2040_6066;

	// requested-state decode: {valid, mode}
	function automatic logic [3:0] decode_pstate(input logic [PST_W-1:0] ps);
		logic c;
		c = ps[PST_CACHE_BIT];
		case (ps[3:0])
			PST_WARM: decode_pstate = {1'b1, M_WARM};
			PST_ON: decode_pstate = {1'b1, c ? M_ON_C : M_ON_NC};
			PST_FULL: decode_pstate = {1'b1, c ? M_FULLRET_C : M_FULLRET_NC};
			PST_MEM: decode_pstate = {1'b1, c ? M_MEMRET_C : M_MEMRET_NC};
			PST_OFF: decode_pstate = {1'b1, M_OFF};
			default: decode_pstate = {1'b0, M_OFF};
		endcase
	endfunction

	// true for the with-cache variants
	function automatic logic has_cache(input mode_t m);
		has_cache = (m == M_ON_C) || (m == M_FULLRET_C) || (m == M_MEMRET_C);
	endfunction

	// true for either full-on mode
	function automatic logic is_on(input mode_t m);
		is_on = (m == M_ON_C) || (m == M_ON_NC);
	endfunction

	// one-hot mode bit plus cache bit, zero for off, warm and no-cache memory retention
	function automatic logic [HINT_W-1:0] mode_hint(input mode_t m);
		logic [HINT_W-1:0] h;
		h = '0;
		case (m)
			M_ON_C, M_ON_NC: h[HINT_ON_BIT] = 1'b1;
			M_FULLRET_C, M_FULLRET_NC: h[HINT_FULL_BIT] = 1'b1;
			M_MEMRET_C: h[HINT_MEM_BIT] = 1'b1;
			default: h = '0;
		endcase
		h[HINT_CACHE_BIT] = has_cache(m);
		mode_hint = h;
	endfunction
endpackage
